/* rtl/adc_conv_params.svh */
// Offsets, field positions, reset values and timing counts for conversion control.
// Assumes inclusion from the conversion control module; the package does not include it.
`ifndef ADC_CONV_PARAMS_SVH
`define ADC_CONV_PARAMS_SVH
`define OFS_CONV_CONTROL_A 4'h0
`define OFS_CONV_CONTROL_B 4'h1
`define OFS_RESULT_LOW 4'h2
`define OFS_RESULT_HIGH 4'h3
`define OFS_ANALOG_ROUTE 4'h4
`define OFS_IRQ_CONTROL 4'h5
`define CTLA_START_BIT 7
`define CTLA_BUSY_BIT 6
`define CTLA_ENABLE_BIT 5
`define CTLA_ALIGN_BIT 4
`define CTLA_RESET 8'h00
`define CTLB_RESET 8'h00
`define SAMPLE_CLOCKS 5'h04
`define TOTAL_CLOCKS 5'h10
`define CHANNEL_COUNT 12
`endif

/* rtl/adc_conv_pkg.sv */
// Types shared by the conversion control block and its bench.
// Assumes adc_conv_params.svh on the include path.
package adc_conv_pkg;
	typedef enum logic [1:0] {REF_EXT_A, REF_INT, REF_EXT_B, REF_EXT_C} ref_sel_t;
	typedef struct packed {
		logic [2:0] inputSource;
		logic [1:0] referenceSelect;
		logic [2:0] clockDivSelect;
	} ctl_b_t;
	typedef struct packed {
		logic [11:0] channelOn;
		logic bandgapOn;
		logic groundOn;
		logic externalRefOn;
		logic supplyRefOn;
		logic powerOn;
		logic sampling;
	} analog_route_t;
	typedef enum logic [1:0] {IDLE, ARMED, SAMPLE, CONVERT} conv_state_t;
endpackage

/* rtl/adc_conversion_control.sv */
// Control logic of one 12-bit successive-approximation converter.
// Assumes a synchronous register port and an analog core that returns one
// result bit per converter clock, most significant first.
// The converter clock only runs while a conversion is under way.
//
// Functional notes
// [RULE_01] Reference select 00 or 1x routes the external reference pin.
// [RULE_02] Reference select 01 uses internal supply; software deselects pin.
// [RULE_03] Source 000, 101, 11x converts the external channel chosen.
// [RULE_04] Source 001, 01x, 100 feeds an internal signal instead.
// [RULE_05] Channel codes 0000 to 1011 connect analog pins 0 to 11.
// [RULE_06] Channel code 11xx connects no external pin.
// [RULE_07] Source 001 routes the bandgap voltage to the input.
// [RULE_08] Source 010, 011, 100 ground the converter input.
// [RULE_09] Software sets channel 11xx whenever an internal signal is used.
// [RULE_10] Start bit written high then low begins one conversion.
// [RULE_11] Busy flag set when started, cleared on completion.
// [RULE_12] Completion sets interrupt request; output gated by enable.
// [RULE_13] Converter clock is system clock divided by 2 to the code.
// [RULE_14] Software keeps converter clock period within 0.5 to 10 us.
// [RULE_15] Converter powered only while enable bit is high.
// [RULE_16] Software waits a settling delay after enabling.
// [RULE_17] Sampling lasts exactly 4 converter clocks.
// [RULE_18] Conversion lasts 12 more clocks, 16 in total.
// [RULE_19] Converter input pins lose pull-high and direction control.
// [RULE_20] Alignment bit places result left or right across two bytes.
// [RULE_21] Result bytes keep contents while converter disabled.
// [RULE_22] Result written at end of clock 16 as busy clears.
`timescale 1ns/1ps
`include "adc_conv_params.svh"

module adc_conversion_control (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clkEnable,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regReadData,
	input wire logic [11:0] pinIsAnalog,
	input wire logic compareBit,
	output adc_conv_pkg::analog_route_t analogRoute,
	output logic convClockTick,
	output logic [11:0] pullHighDisable,
	output logic [11:0] portDirOverride,
	output logic irqRequest,
	output logic irqOut
);
	logic rstMeta;
	logic rstSync;
	logic [7:0] ctlA;
	adc_conv_pkg::ctl_b_t ctlB;
	logic irqEnable;
	logic busy;
	logic [11:0] resultData;
	logic [11:0] shiftReg;
	logic [6:0] divCount;
	logic [4:0] clockCount;
	adc_conv_pkg::conv_state_t state;
	logic startBit;
	logic powerOn;
	logic alignRight;
	logic external;
	logic [7:0] resultLow;
	logic [7:0] resultHigh;
	logic divTick;
	logic finish;
	logic [6:0] divMask;
	logic active;
	logic [11:0] channelHit;

	// Async assert, sync release
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	assign startBit = ctlA[`CTLA_START_BIT];
	assign powerOn = ctlA[`CTLA_ENABLE_BIT];
	assign alignRight = ctlA[`CTLA_ALIGN_BIT];

	// Control registers; busy bit is read-only so never stored here
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			ctlA <= `CTLA_RESET;
			ctlB <= `CTLB_RESET;
		end else if (clkEnable && regWrite) begin
			case (regAddr)
				`OFS_CONV_CONTROL_A: ctlA <= {regWriteData[7], 1'b0,
					regWriteData[5:0]};
				`OFS_CONV_CONTROL_B: ctlB <= regWriteData;
				default: ;
			endcase
		end
	end

	// Interrupt enable lives apart from the converter controls;
	// the request flag itself is cleared by the same register
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			irqEnable <= 1'b0;
		end else if (clkEnable && regWrite &&
			regAddr == `OFS_IRQ_CONTROL) begin
			irqEnable <= regWriteData[0]; // [RULE_12]
		end
	end

	// Sampling and converting are the only phases that use the clock
	assign active = state == adc_conv_pkg::SAMPLE ||
		state == adc_conv_pkg::CONVERT;

	// Divider mask: code n divides by 2**n
	assign divMask = 7'((8'h01 << ctlB.clockDivSelect) - 8'h01); // [RULE_13]
	assign divTick = ((divCount & divMask) == divMask); // [RULE_13]

	// Only a running conversion turns the divider, so each one opens
	// on a whole converter period
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			divCount <= 7'h00;
		end else if (clkEnable) begin
			if (!powerOn || !active)
				divCount <= 7'h00;
			else if (divTick)
				divCount <= 7'h00;
			else
				divCount <= divCount + 7'h01;
		end
	end

	assign finish = (state == adc_conv_pkg::CONVERT) && divTick &&
		(clockCount == `TOTAL_CLOCKS - 5'h01);

	// Start detect: rising then falling of the start bit
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			state <= adc_conv_pkg::IDLE;
			clockCount <= 5'h00;
			busy <= 1'b0;
		end else if (clkEnable) begin
			if (!powerOn) begin
				// Power-off aborts; results stay untouched
				state <= adc_conv_pkg::IDLE; // [RULE_15]
				busy <= 1'b0;
				clockCount <= 5'h00;
			end else begin
				case (state)
					adc_conv_pkg::IDLE:
						if (startBit)
							state <= adc_conv_pkg::ARMED; // [RULE_10]
					// A start bit left high waits here for its fall
					adc_conv_pkg::ARMED:
						if (!startBit) begin
							state <= adc_conv_pkg::SAMPLE; // [RULE_10]
							busy <= 1'b1; // [RULE_11]
							clockCount <= 5'h00;
						end
					// Clock count runs on across the phase change
					adc_conv_pkg::SAMPLE:
						if (divTick) begin
							clockCount <= clockCount + 5'h01;
							if (clockCount == `SAMPLE_CLOCKS - 5'h01)
								state <= adc_conv_pkg::CONVERT; // [RULE_17]
						end
					adc_conv_pkg::CONVERT:
						if (divTick) begin
							clockCount <= clockCount + 5'h01;
							if (finish) begin
								state <= adc_conv_pkg::IDLE; // [RULE_18]
								busy <= 1'b0; // [RULE_11]
								clockCount <= 5'h00;
							end
						end
					default: state <= adc_conv_pkg::IDLE;
				endcase
			end
		end
	end

	// Shift in one decision per conversion clock
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			shiftReg <= 12'h000;
		end else if (clkEnable && state == adc_conv_pkg::CONVERT && divTick) begin
			shiftReg <= {shiftReg[10:0], compareBit}; // [RULE_18]
		end
	end

	// Result lands only on a powered, completed conversion
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			resultData <= 12'h000;
		end else if (clkEnable && powerOn && finish) begin
			resultData <= {shiftReg[10:0], compareBit}; // [RULE_22] [RULE_21]
		end
	end

	// Request flag: completion wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			irqRequest <= 1'b0;
		end else if (clkEnable) begin
			if (finish && powerOn)
				irqRequest <= 1'b1; // [RULE_12]
			else if (regWrite && regAddr == `OFS_IRQ_CONTROL && regWriteData[1])
				irqRequest <= 1'b0;
		end
	end

	// Request stays visible ungated so software can poll it
	assign irqOut = irqRequest & irqEnable; // [RULE_12]

	// Alignment of the two result bytes
	always_comb begin
		if (alignRight) begin
			resultHigh = {4'h0, resultData[11:8]}; // [RULE_20]
			resultLow = resultData[7:0]; // [RULE_20]
		end else begin
			resultHigh = resultData[11:4]; // [RULE_20]
			resultLow = {resultData[3:0], 4'h0}; // [RULE_20]
		end
	end

	// Sources 000, 101 and 11x take an external pin
	assign external = (ctlB.inputSource == 3'h0) ||
		(ctlB.inputSource == 3'h5) || ctlB.inputSource[2:1] == 2'h3; // [RULE_03]

	// One decoder per pin; codes 11xx match no pin index, so the input
	// floats rather than shorting a pin onto an internal source
	for (genvar g = 0; g < `CHANNEL_COUNT; g++) begin : g_chan
		assign channelHit[g] = external &&
			ctlA[3:0] == 4'(g); // [RULE_05] [RULE_06]
	end

	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			analogRoute <= '0;
		end else if (clkEnable) begin
			analogRoute.channelOn <= channelHit; // [RULE_05] [RULE_06]
			analogRoute.bandgapOn <= ctlB.inputSource == 3'h1; // [RULE_07] [RULE_04]
			analogRoute.groundOn <= ctlB.inputSource == 3'h2 ||
				ctlB.inputSource == 3'h3 ||
				ctlB.inputSource == 3'h4; // [RULE_08] [RULE_04]
			analogRoute.externalRefOn <=
				ctlB.referenceSelect != 2'h1; // [RULE_01]
			analogRoute.supplyRefOn <=
				ctlB.referenceSelect == 2'h1; // [RULE_02]
			analogRoute.powerOn <= powerOn; // [RULE_15]
			analogRoute.sampling <= state == adc_conv_pkg::SAMPLE; // [RULE_17]
		end
	end

	// Tick mirrors the converter clock only while a conversion runs,
	// so an observer counts exactly sixteen per conversion
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			convClockTick <= 1'b0;
		end else if (clkEnable) begin
			convClockTick <= divTick && active && powerOn; // [RULE_18]
		end
	end

	// Pin overrides follow the pin-function bits with no further gating;
	// analog use then needs no direction setup
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			pullHighDisable <= 12'h000;
			portDirOverride <= 12'h000;
		end else if (clkEnable) begin
			pullHighDisable <= pinIsAnalog; // [RULE_19]
			portDirOverride <= pinIsAnalog; // [RULE_19]
		end
	end

	// Read data valid the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			regReadData <= 8'h00;
		end else if (clkEnable) begin
			if (regRead) begin
				case (regAddr)
					`OFS_CONV_CONTROL_A: regReadData <= {ctlA[7], busy, ctlA[5:0]};
					`OFS_CONV_CONTROL_B: regReadData <= ctlB;
					`OFS_RESULT_LOW: regReadData <= resultLow;
					`OFS_RESULT_HIGH: regReadData <= resultHigh;
					`OFS_IRQ_CONTROL: regReadData <= {6'h00, irqRequest, irqEnable};
					default: regReadData <= 8'h00;
				endcase
			end else begin
				// Bus sees zero outside the answer slot
				regReadData <= 8'h00;
			end
		end
	end
endmodule // adc_conversion_control

/* dv/adc_conversion_control_chk.sv */
// Port-level checker for the conversion control block.
// Assumes binding into adc_conversion_control.
`timescale 1ns/1ps
module adc_conversion_control_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clkEnable,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regReadData,
	input wire logic [11:0] pinIsAnalog,
	input wire adc_conv_pkg::analog_route_t analogRoute,
	input wire logic convClockTick,
	input wire logic [11:0] pullHighDisable,
	input wire logic [11:0] portDirOverride,
	input wire logic irqRequest,
	input wire logic irqOut
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire logic clrWr = regWrite && regAddr == 4'h5 && regWriteData[1];
	a_pull_copy: assert property (clkEnable |=>
		pullHighDisable == $past(pinIsAnalog)) else $error("pull-high copy");
	a_dir_copy: assert property (portDirOverride == pullHighDisable)
		else $error("direction override");
	a_irq_gate: assert property (irqOut |-> irqRequest)
		else $error("irq out without request");
	a_irq_hold: assert property (irqRequest && !clrWr |=> irqRequest)
		else $error("irq request lost");
	a_src_excl: assert property (!(analogRoute.bandgapOn &&
		analogRoute.groundOn)) else $error("bandgap and ground");
	a_ref_excl: assert property (!(analogRoute.externalRefOn &&
		analogRoute.supplyRefOn)) else $error("two references");
	a_tick_power: assert property (convClockTick |->
		analogRoute.powerOn) else $error("tick while unpowered");
	a_chan_one: assert property ($onehot0(analogRoute.channelOn))
		else $error("several channels");
	a_read_idle: assert property (!regRead |=> regReadData == 8'h00)
		else $error("read data outside slot");
endmodule // adc_conversion_control_chk

bind adc_conversion_control adc_conversion_control_chk chk_i (.clk_sys,
	.rst_b, .clkEnable, .regAddr, .regWriteData, .regWrite, .regRead,
	.regReadData, .pinIsAnalog, .analogRoute, .convClockTick,
	.pullHighDisable, .portDirOverride, .irqRequest, .irqOut);

/* dv/adc_conversion_control_test.sv */
// Register-level bench for the conversion control block.
// Assumes the design is compiled first; single 25 MHz clock.
`timescale 1ns/1ps
module adc_conversion_control_test;
	logic clk_sys = 0, rst_b = 0, regWrite = 0, regRead = 0, compareBit = 0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWriteData = 8'h00, regReadData;
	logic [11:0] pinIsAnalog = 12'h000, pullHighDisable, portDirOverride, r;
	logic convClockTick, irqRequest, irqOut;
	adc_conv_pkg::analog_route_t analogRoute;
	int errors = 0, n_compared = 0, cyc = 0, last = 0, gap = 0, ticks = 0;
	int i, k;
	always #20 clk_sys = ~clk_sys;
	adc_conversion_control uut (.clk_sys, .rst_b, .clkEnable(1'b1), .regAddr,
		.regWriteData, .regWrite, .regRead, .regReadData, .pinIsAnalog,
		.compareBit, .analogRoute, .convClockTick, .pullHighDisable,
		.portDirOverride, .irqRequest, .irqOut);
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (convClockTick) begin
			ticks <= ticks + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end
	task automatic wrap_up();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string n, logic [11:0] e, logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e, string n);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk(n, {4'h0, e}, {4'h0, regReadData});
	endtask
	initial begin
		#2000000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(4'h0, 8'h00, "ctl a");
		rd(4'h1, 8'h00, "ctl b");
		rd(4'h4, 8'h00, "reserved");
		rd(4'h9, 8'h00, "unmapped");
		for (i = 0; i < 8; i++) begin
			// Source 6 keeps the floating 11xx case for an external source
			k = (i == 0 || i == 5 || i == 7) ? i + 4 : 12;
			r = (k < 12) ? 12'h001 << k : 12'h000;
			wr(4'h1, {i[2:0], i[1:0], 3'h0});
			wr(4'h0, 8'h20 | k[7:0]);
			repeat (3) @(posedge clk_sys);
			#1 chk("channels", r, analogRoute.channelOn);
			chk("route", {7'h00, i == 1, i > 1 && i < 5, i[1:0] != 2'h1,
				i[1:0] == 2'h1, 1'b1}, {7'h00, analogRoute.bandgapOn,
				analogRoute.groundOn, analogRoute.externalRefOn,
				analogRoute.supplyRefOn, analogRoute.powerOn});
		end
		pinIsAnalog <= 12'ha5c;
		repeat (2) @(posedge clk_sys);
		#1 chk("pull-high", 12'ha5c, pullHighDisable);
		for (i = 0; i < 8; i++) begin
			compareBit <= i[1];
			r = i[1] ? 12'hfff : 12'h000;
			wr(4'h5, 8'h02);
			wr(4'h1, {5'h00, i[2:0]});
			wr(4'h0, {3'h1, i[0], 4'h0});
			repeat (4) @(posedge clk_sys);
			wr(4'h0, {3'h5, i[0], 4'h0});
			rd(4'h0, {3'h5, i[0], 4'h0}, "no start on rise");
			wr(4'h0, {3'h1, i[0], 4'h0});
			k = ticks;
			rd(4'h0, {3'h3, i[0], 4'h0}, "busy");
			for (int w = 0; w < 3000 && irqRequest !== 1'b1; w++)
				@(posedge clk_sys);
			repeat (2) @(posedge clk_sys);
			#1 chk("ticks", 12'h010, 12'(ticks - k));
			chk("tick gap", 12'h001 << i, 12'(gap));
			rd(4'h0, {3'h1, i[0], 4'h0}, "idle");
			rd(4'h3, i[0] ? {4'h0, r[11:8]} : r[11:4], "high");
			rd(4'h2, i[0] ? r[7:0] : {r[3:0], 4'h0}, "low");
		end
		chk("irq gated", 12'h000, {11'h000, irqOut});
		wr(4'h5, 8'h01);
		@(posedge clk_sys);
		#1 chk("irq out", 12'h001, {11'h000, irqOut});
		rd(4'h5, 8'h03, "irq ctl");
		wr(4'h5, 8'h03);
		rd(4'h5, 8'h01, "irq cleared");
		wr(4'h0, 8'h50);
		rd(4'h0, 8'h10, "busy read-only");
		rd(4'h3, 8'h0f, "kept high");
		rd(4'h2, 8'hff, "kept low");
		wrap_up();
	end
endmodule // adc_conversion_control_test
